// ---- src/uds_ctrl.sv ----
// uart channel service logic: irq mode, dma requests, sleep, break, baud
// Operation
// [R1] any of the low four irq enable bits set selects interrupt mode
// [R2] all four low irq enable bits clear gives polled mode via line status
// [R3] fifo control bit 3 picks dma mode 0 or mode 1
// [R4] mode 0 or fifo disabled gives single transfers, mode 1 block transfers
// [R5] single mode: tx request active while tx empty, drops on first load
// [R6] single mode: rx request active while any character held
// [R7] block mode: tx request on trigger free space, drops when fifo full
// [R8] block mode: rx request on trigger or timeout, drops on empty or error
// [R9] sleep allowed only with enhanced bit and sleep enable bit set
// [R10] sleep needs rx idle, tx empty and no other interrupt pending
// [R11] no sleep while receive fifo holds data
// [R12] asleep, uart clock and baud clock both stop
// [R13] wake on rx change, modem pin change or tx fifo write
// [R14] host must not write divisor bytes while asleep
// [R15] rx idle after line high for four word lengths plus twelve bits
// [R16] receive line sampled mid bit
// [R17] line control bit 6 holds tx output low for break
// [R18] baud divisor 1 to 65535 gives sixteen times baud tick
// [R19] modem control bit 7 adds divide by four prescaler, off at reset
// [R20] divisor built from low and high byte latches
// [R21] zero divisor produces no baud tick
// [R22] one baud tick clocks both transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module uds_ctrl
#(
  parameter int FIFO_DEPTH = 64,
  parameter int LW = $clog2(FIFO_DEPTH + 1)
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // fifo and shifter status, same clock
  input wire logic [LW-1:0] txFifoLevel,
  input wire logic [LW-1:0] rxFifoLevel,
  input wire logic [LW-1:0] txTrigger,
  input wire logic [LW-1:0] rxTrigger,
  input wire logic txFifoWrite,
  input wire logic txShiftEmpty,
  input wire logic txSerial,
  input wire logic rxTimeoutIrq,
  input wire logic rxFifoError,
  input wire logic irqPending,
  input wire logic otherIrqPending,
  input wire logic [7:0] lineStatus,
  // serial and modem pins
  input wire logic rxPin,
  input wire logic [3:0] modemPins,
  output logic txPin,
  // host side outputs
  output logic irqOut,
  output logic tx_dma_request_n,
  output logic rx_dma_request_n,
  output logic uartClockEnable,
  output logic baudTick16,
  output logic [7:0] lineControl
);
  import uds_pkg::*;

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255)
  begin : gDepthCheck
    $error("FIFO_DEPTH must lie in 2..255");
  end

  localparam logic [LW-1:0] DEPTH_L = LW'(FIFO_DEPTH);
  localparam logic [LW-1:0] LEVEL_ZERO = '0;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic ack_q;
  logic wrEn;
  logic [31:0] readdata_q;

  // one wait cycle for every access keeps read data registered
  assign waitrequest = (read || write) && !ack_q;
  assign wrEn = write && ack_q && byteenable[0];
  assign readdata = readdata_q;

  always_ff @(posedge clock)
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= (read || write) && !ack_q;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] irqEnable_q;
  logic [7:0] fifoControl_q;
  logic [7:0] lineControl_q;
  logic [7:0] modemControl_q;
  logic [7:0] enhFeature_q;
  logic [7:0] divLow_q;
  logic [7:0] divHigh_q;

  always_ff @(posedge clock)
    if (rst)
      irqEnable_q <= RST_ZERO;
    else if (wrEn && address == OFS_IRQ_ENABLE)
      irqEnable_q <= writedata[7:0];

  always_ff @(posedge clock)
    if (rst)
      fifoControl_q <= RST_ZERO;
    else if (wrEn && address == OFS_FIFO_CONTROL)
      fifoControl_q <= writedata[7:0];

  always_ff @(posedge clock)
    if (rst)
      lineControl_q <= RST_LINE_CONTROL;
    else if (wrEn && address == OFS_LINE_CONTROL)
      lineControl_q <= writedata[7:0];

  always_ff @(posedge clock)
    if (rst)
      modemControl_q <= RST_ZERO;
    else if (wrEn && address == OFS_MODEM_CONTROL)
      modemControl_q <= writedata[7:0];

  always_ff @(posedge clock)
    if (rst)
      enhFeature_q <= RST_ZERO;
    else if (wrEn && address == OFS_ENH_FEATURE)
      enhFeature_q <= writedata[7:0];

  // divisor writes are accepted even asleep; the host keeps off them then
  always_ff @(posedge clock)
    if (rst)
      divLow_q <= RST_ZERO;
    else if (wrEn && address == OFS_DIV_LOW) // R20 R14
      divLow_q <= writedata[7:0];

  always_ff @(posedge clock)
    if (rst)
      divHigh_q <= RST_ZERO;
    else if (wrEn && address == OFS_DIV_HIGH) // R20 R14
      divHigh_q <= writedata[7:0];

  assign lineControl = lineControl_q;

  // ----------------------------------------------------------------
  // pin synchronisers and change detection
  // ----------------------------------------------------------------
  logic [4:0] pinMeta_q;
  logic [4:0] pinSync_q;
  logic [4:0] pinPrev_q;
  logic rxChanged;
  logic modemChanged;

  always_ff @(posedge clock)
    if (rst)
      pinMeta_q <= 5'h1F;
    else
      pinMeta_q <= {modemPins, rxPin};

  always_ff @(posedge clock)
    if (rst)
      pinSync_q <= 5'h1F;
    else
      pinSync_q <= pinMeta_q;

  always_ff @(posedge clock)
    if (rst)
      pinPrev_q <= 5'h1F;
    else
      pinPrev_q <= pinSync_q;

  assign rxChanged = pinSync_q[0] != pinPrev_q[0];
  assign modemChanged = pinSync_q[4:1] != pinPrev_q[4:1];

  // ----------------------------------------------------------------
  // interrupt or polled mode
  // ----------------------------------------------------------------
  logic intMode;
  logic irqOut_q;

  assign intMode = irqEnable_q[3:0] != 4'h0; // R1 R2

  always_ff @(posedge clock)
    if (rst)
      irqOut_q <= 1'b0;
    else
      irqOut_q <= intMode && irqPending; // R1 R2

  assign irqOut = irqOut_q;

  // ----------------------------------------------------------------
  // dma request signalling
  // ----------------------------------------------------------------
  logic blockMode;
  logic txBlk_q;
  logic rxBlk_q;
  logic txBlk_d;
  logic rxBlk_d;
  logic txReqN_q;
  logic rxReqN_q;

  assign blockMode = fifoControl_q[DMA_MODE_BIT] && fifoControl_q[FIFO_EN_BIT]; // R3 R4

  // tx full, and rx error or empty, take precedence over a new trigger
  always_comb
  begin
    txBlk_d = txBlk_q;
    if (txFifoLevel == DEPTH_L) // R7
      txBlk_d = 1'b0;
    else if (DEPTH_L - txFifoLevel >= txTrigger) // R7
      txBlk_d = 1'b1;
    rxBlk_d = rxBlk_q;
    if (rxFifoLevel == LEVEL_ZERO || rxFifoError) // R8
      rxBlk_d = 1'b0;
    else if (rxFifoLevel >= rxTrigger || rxTimeoutIrq) // R8
      rxBlk_d = 1'b1;
  end

  always_ff @(posedge clock)
    if (rst)
      txBlk_q <= 1'b0;
    else
      txBlk_q <= txBlk_d;

  always_ff @(posedge clock)
    if (rst)
      rxBlk_q <= 1'b0;
    else
      rxBlk_q <= rxBlk_d;

  always_ff @(posedge clock)
    if (rst)
      txReqN_q <= 1'b0;
    else if (blockMode)
      txReqN_q <= !txBlk_d; // R7
    else
      txReqN_q <= txFifoLevel != LEVEL_ZERO; // R5

  always_ff @(posedge clock)
    if (rst)
      rxReqN_q <= 1'b1;
    else if (blockMode)
      rxReqN_q <= !rxBlk_d; // R8
    else
      rxReqN_q <= rxFifoLevel == LEVEL_ZERO; // R6

  assign tx_dma_request_n = txReqN_q;
  assign rx_dma_request_n = rxReqN_q;

  // ----------------------------------------------------------------
  // sleep control
  // ----------------------------------------------------------------
  uds_power_t power_q;
  logic sleepPermit;
  logic sleepReady;
  logic wake;
  logic rxIdle;

  assign sleepPermit = enhFeature_q[ENH_EN_BIT] && irqEnable_q[SLEEP_EN_BIT]; // R9
  assign sleepReady = rxIdle && txFifoLevel == LEVEL_ZERO && txShiftEmpty
                      && !otherIrqPending && rxFifoLevel == LEVEL_ZERO; // R10 R11
  assign wake = rxChanged || modemChanged || txFifoWrite; // R13

  always_ff @(posedge clock)
    if (rst)
      power_q <= UDS_AWAKE;
    else
      case (power_q)
        UDS_AWAKE:
          if (sleepPermit && sleepReady && !wake) // R9 R10 R11
            power_q <= UDS_ASLEEP;
        UDS_ASLEEP:
          if (wake || !sleepPermit) // R13
            power_q <= UDS_AWAKE;
        default:
          power_q <= UDS_AWAKE;
      endcase

  assign uartClockEnable = power_q == UDS_AWAKE; // R12

  // ----------------------------------------------------------------
  // break and transmit pin
  // ----------------------------------------------------------------
  logic txPin_q;

  always_ff @(posedge clock)
    if (rst)
      txPin_q <= 1'b1;
    else
      txPin_q <= lineControl_q[BREAK_BIT] ? 1'b0 : txSerial; // R17

  assign txPin = txPin_q;

  // ----------------------------------------------------------------
  // baud generator and idle detector
  // ----------------------------------------------------------------
  uds_baud_if baudBus();

  assign baudBus.divisor = {divHigh_q, divLow_q}; // R20
  assign baudBus.prescale4 = modemControl_q[PRESCALE_BIT]; // R19
  assign baudBus.run = power_q == UDS_AWAKE; // R12
  assign baudBus.rxLevel = pinSync_q[0];
  assign baudBus.wordLen = lineControl_q[1:0];
  assign rxIdle = baudBus.rxIdle;
  assign baudTick16 = baudBus.tick16; // R22

  uds_baud_gen uBaud
  (
    .clock(clock),
    .rst(rst),
    .bus(baudBus)
  );

  uds_rx_idle uIdle
  (
    .clock(clock),
    .rst(rst),
    .bus(baudBus)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
    if (rst)
      readdata_q <= 32'h0000_0000;
    else if (read && !ack_q)
      case (address)
        OFS_IRQ_ENABLE: readdata_q <= {24'h000000, irqEnable_q};
        OFS_FIFO_CONTROL: readdata_q <= {24'h000000, fifoControl_q};
        OFS_LINE_CONTROL: readdata_q <= {24'h000000, lineControl_q};
        OFS_MODEM_CONTROL: readdata_q <= {24'h000000, modemControl_q};
        OFS_ENH_FEATURE: readdata_q <= {24'h000000, enhFeature_q};
        OFS_DIV_LOW: readdata_q <= {24'h000000, divLow_q};
        OFS_DIV_HIGH: readdata_q <= {24'h000000, divHigh_q};
        OFS_STATUS: readdata_q <= {16'h0000, power_q == UDS_ASLEEP, intMode, rxIdle,
                                   txReqN_q, rxReqN_q, 3'h0, lineStatus}; // R2
        default: readdata_q <= 32'h0000_0000;
      endcase

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  irq_mode_a: assert property (@(posedge clock) disable iff (rst)
    irqPending && irqEnable_q[3:0] != 4'h0 |=> irqOut) // R1
    else $error("pending irq not raised in interrupt mode");
  polled_quiet_a: assert property (@(posedge clock) disable iff (rst)
    irqEnable_q[3:0] == 4'h0 |=> !irqOut) // R2
    else $error("irq raised in polled mode");
  tx_single_a: assert property (@(posedge clock) disable iff (rst)
    !fifoControl_q[DMA_MODE_BIT] && txFifoLevel == LEVEL_ZERO |=> !tx_dma_request_n) // R4 R5
    else $error("single tx request not active on empty");
  rx_single_a: assert property (@(posedge clock) disable iff (rst)
    !fifoControl_q[FIFO_EN_BIT] |-> ##1 (rx_dma_request_n == $past(rxFifoLevel == LEVEL_ZERO))) // R4 R6
    else $error("single rx request wrong");
  tx_block_full_a: assert property (@(posedge clock) disable iff (rst)
    blockMode && txFifoLevel == DEPTH_L |=> tx_dma_request_n) // R3 R7
    else $error("block tx request active on full");
  rx_block_clr_a: assert property (@(posedge clock) disable iff (rst)
    blockMode && (rxFifoLevel == LEVEL_ZERO || rxFifoError) |=> rx_dma_request_n) // R8
    else $error("block rx request active on empty or error");
  sleep_permit_a: assert property (@(posedge clock) disable iff (rst)
    !(enhFeature_q[ENH_EN_BIT] && irqEnable_q[SLEEP_EN_BIT]) |=> uartClockEnable) // R9
    else $error("asleep without permission");
  sleep_rx_data_a: assert property (@(posedge clock) disable iff (rst)
    uartClockEnable && (rxFifoLevel != LEVEL_ZERO || otherIrqPending) |=> uartClockEnable) // R10 R11
    else $error("slept with rx data or irq pending");
  wake_write_a: assert property (@(posedge clock) disable iff (rst)
    !uartClockEnable && txFifoWrite |=> uartClockEnable) // R13
    else $error("no wake on tx fifo write");
  break_low_a: assert property (@(posedge clock) disable iff (rst)
    lineControl_q[BREAK_BIT] |=> !txPin) // R17
    else $error("break not driving tx low");
endmodule : uds_ctrl
`default_nettype wire

// ---- src/uds_pkg.sv ----
// shared constants and types of the uart service controller
package uds_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the avalon slave
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h00;
  localparam logic [4:0] OFS_FIFO_CONTROL = 5'h04;
  localparam logic [4:0] OFS_LINE_CONTROL = 5'h08;
  localparam logic [4:0] OFS_MODEM_CONTROL = 5'h0C;
  localparam logic [4:0] OFS_ENH_FEATURE = 5'h10;
  localparam logic [4:0] OFS_DIV_LOW = 5'h14;
  localparam logic [4:0] OFS_DIV_HIGH = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1C;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FIFO_EN_BIT = 0;
  localparam int DMA_MODE_BIT = 3;
  localparam int SLEEP_EN_BIT = 4;
  localparam int ENH_EN_BIT = 4;
  localparam int BREAK_BIT = 6;
  localparam int PRESCALE_BIT = 7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LINE_CONTROL = 8'h1D;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [3:0] MID_BIT_PHASE = 4'h7;
  localparam logic [5:0] IDLE_WORD_MULT = 6'h04;
  localparam logic [5:0] IDLE_EXTRA_BITS = 6'h0C;
  localparam logic [5:0] CHAR_BASE_BITS = 6'h05;

  typedef enum logic {UDS_AWAKE, UDS_ASLEEP} uds_power_t;

endpackage : uds_pkg

// ---- src/uds_baud_if.sv ----
// baud tick and idle signals shared by the controller and its helpers
`timescale 1ns/1ps
`default_nettype none
interface uds_baud_if;
  logic [15:0] divisor;
  logic prescale4;
  logic run;
  logic tick16;
  logic rxLevel;
  logic [1:0] wordLen;
  logic rxIdle;

  modport gen (input divisor, input prescale4, input run, output tick16);
  modport idle (input tick16, input rxLevel, input wordLen, output rxIdle);
  modport ctrl (output divisor, output prescale4, output run, output rxLevel, output wordLen,
                input tick16, input rxIdle);
endinterface : uds_baud_if
`default_nettype wire

// ---- src/uds_baud_gen.sv ----
// prescaler and 16-bit divisor producing the 16x baud tick
`timescale 1ns/1ps
`default_nettype none
module uds_baud_gen
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // divisor settings in, tick out
  uds_baud_if.gen bus
);
  import uds_pkg::*;

  logic [1:0] pre_q;
  logic [15:0] cnt_q;
  logic preTick;
  logic wrap;

  assign preTick = bus.prescale4 ? (pre_q == PRESCALE_LAST) : 1'b1; // R19
  assign wrap = cnt_q >= (bus.divisor - 16'h0001); // R18

  // counters clear and stay at zero while asleep
  always_ff @(posedge clock)
    if (rst || !bus.run)
      pre_q <= 2'h0;
    else
      pre_q <= pre_q + 2'h1;

  always_ff @(posedge clock)
    if (rst || !bus.run)
      cnt_q <= 16'h0000;
    else if (preTick)
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;

  always_ff @(posedge clock)
    if (rst)
      bus.tick16 <= 1'b0;
    else
      bus.tick16 <= bus.run && (bus.divisor != 16'h0000) && preTick && wrap; // R12 R18 R21

  baud_stop_a: assert property (@(posedge clock) disable iff (rst) !bus.run |=> !bus.tick16) // R12
    else $error("baud tick while clocks stopped");
  div_zero_a: assert property (@(posedge clock) disable iff (rst) bus.divisor == 16'h0000 |=> !bus.tick16) // R21
    else $error("baud tick with zero divisor");
  prescale_gap_a: assert property (@(posedge clock) disable iff (rst)
    bus.tick16 && $past(bus.prescale4) |-> !$past(bus.tick16)) // R19
    else $error("prescaler did not divide");
endmodule : uds_baud_gen
`default_nettype wire

// ---- src/uds_rx_idle.sv ----
// receive idle detector counting high mid-bit samples
`timescale 1ns/1ps
`default_nettype none
module uds_rx_idle
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // tick and line in, idle out
  uds_baud_if.idle bus
);
  import uds_pkg::*;

  logic [3:0] phase_q;
  logic [5:0] bits_q;
  logic [5:0] needBits;

  assign needBits = IDLE_WORD_MULT * (CHAR_BASE_BITS + {4'h0, bus.wordLen}) + IDLE_EXTRA_BITS; // R15

  // a low level restarts bit alignment, as a start bit would
  always_ff @(posedge clock)
    if (rst || !bus.rxLevel)
      phase_q <= 4'h0;
    else if (bus.tick16)
      phase_q <= phase_q + 4'h1;

  always_ff @(posedge clock)
    if (rst || !bus.rxLevel)
      bits_q <= 6'h00;
    else if (bus.tick16 && phase_q == MID_BIT_PHASE && bits_q != 6'h3F) // R16 R22
      bits_q <= bits_q + 6'h01;

  always_ff @(posedge clock)
    if (rst)
      bus.rxIdle <= 1'b0;
    else
      bus.rxIdle <= bus.rxLevel && (bits_q >= needBits); // R15

  rx_low_busy_a: assert property (@(posedge clock) disable iff (rst) !bus.rxLevel |=> !bus.rxIdle) // R15
    else $error("idle reported with line low");
endmodule : uds_rx_idle
`default_nettype wire

// ---- sim/uds_dma_model.sv ----
// dma controller and fifo fill model facing the request pins
`timescale 1ns/1ps
`default_nettype none
module uds_dma_model
#(
  parameter int DEPTH = 64,
  parameter int LW = 7
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench control
  input wire logic service,
  input wire logic load,
  input wire logic [LW-1:0] loadTx,
  input wire logic [LW-1:0] loadRx,
  // requests in, fifo view out
  input wire logic txReqN,
  input wire logic rxReqN,
  output logic [LW-1:0] txLevel,
  output logic [LW-1:0] rxLevel,
  output logic txWrite
);
  // service low models a stalled controller; one character per cycle when served
  always_ff @(posedge clock)
  begin
    txWrite <= 1'b0;
    if (rst)
    begin
      txLevel <= '0;
      rxLevel <= '0;
    end
    else if (load)
    begin
      txLevel <= loadTx;
      rxLevel <= loadRx;
    end
    else if (service)
    begin
      if (!txReqN && txLevel < LW'(DEPTH))
      begin
        txLevel <= txLevel + 1'b1;
        txWrite <= 1'b1;
      end
      if (!rxReqN && rxLevel != '0)
        rxLevel <= rxLevel - 1'b1;
    end
  end
endmodule : uds_dma_model
`default_nettype wire

// ---- sim/uds_ctrl_tb.sv ----
// self-checking bench for the uart service controller
`timescale 1ns/1ps
`default_nettype none
module uds_ctrl_tb;
  import uds_pkg::*;
  localparam int DEPTH = 64;
  localparam int LW = 7;
  localparam int TTRIG = 8;
  localparam int RTRIG = 16;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = '0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [LW-1:0] txLevel, rxLevel;
  logic [LW-1:0] loadTx = '0;
  logic [LW-1:0] loadRx = '0;
  logic load = 1'b0;
  logic service = 1'b0;
  logic txSerial = 1'b1;
  logic rxTimeoutIrq = 1'b0;
  logic rxFifoError = 1'b0;
  logic irqPending = 1'b0;
  logic [7:0] lineStatus = '0;
  logic rxPin = 1'b1;
  logic [3:0] modemPins = 4'hF;
  logic shiftEmpty = 1'b1, otherIrq = 1'b0;
  logic txFifoWrite, txPin, irqOut, txReqN, rxReqN, clkEn, baudTick16;
  logic [7:0] lineControl;
  int numErrors = 0;
  int cmpCount = 0;
  logic [4:0] ofs [7] = '{OFS_IRQ_ENABLE, OFS_FIFO_CONTROL, OFS_LINE_CONTROL, OFS_MODEM_CONTROL,
                          OFS_ENH_FEATURE, OFS_DIV_LOW, OFS_DIV_HIGH};
  logic [7:0] md [3] = '{8'h00, 8'h01, 8'h08};
  int tt [7] = '{64, 60, 56, 60, 60, 60, 64};
  int rr [7] = '{0, 4, 16, 4, 4, 4, 0};
  logic [6:0] ee = 7'b0010000;
  logic [6:0] oo = 7'b1100000;
  logic [15:0] bd [5] = '{16'h0000, 16'h0003, 16'h0002, 16'h0001, 16'h0100};
  logic [4:0] bp = 5'b00100;
  int bw [5] = '{64, 60, 64, 32, 512};

  uds_ctrl #(.FIFO_DEPTH(DEPTH)) uds_ctrl_inst (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .txFifoLevel(txLevel), .rxFifoLevel(rxLevel), .txTrigger(LW'(TTRIG)),
    .rxTrigger(LW'(RTRIG)), .txFifoWrite(txFifoWrite), .txShiftEmpty(shiftEmpty), .txSerial(txSerial),
    .rxTimeoutIrq(rxTimeoutIrq), .rxFifoError(rxFifoError), .irqPending(irqPending),
    .otherIrqPending(otherIrq), .lineStatus(lineStatus), .rxPin(rxPin), .modemPins(modemPins),
    .txPin(txPin), .irqOut(irqOut), .tx_dma_request_n(txReqN), .rx_dma_request_n(rxReqN),
    .uartClockEnable(clkEn), .baudTick16(baudTick16), .lineControl(lineControl));

  uds_dma_model #(.DEPTH(DEPTH), .LW(LW)) uds_dma_model_inst (.clock(clock), .rst(rst),
    .service(service), .load(load), .loadTx(loadTx), .loadRx(loadRx), .txReqN(txReqN),
    .rxReqN(rxReqN), .txLevel(txLevel), .rxLevel(rxLevel), .txWrite(txFifoWrite));

  initial
  begin
    forever #50 clock = ~clock;
  end

  // block mode requests keep their state between the set and clear thresholds
  function automatic logic [1:0] blockReq(logic [1:0] p, int t, int r, logic e, logic o);
    logic tn, rn;
    tn = (t == DEPTH) ? 1'b1 : ((DEPTH - t >= TTRIG) ? 1'b0 : p[1]);
    rn = (r == 0 || e) ? 1'b1 : ((r >= RTRIG || o) ? 1'b0 : p[0]);
    return {tn, rn};
  endfunction : blockReq

  function automatic int tickExp(int div, logic pre, int w);
    return (div == 0) ? 0 : w / (div * (pre ? 4 : 1));
  endfunction : tickExp

  task automatic test_done();
    $display("errors %0d compares %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20)
    begin
      numErrors++;
      test_done();
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 8'h00, 4'hF, q);
  endtask : rd

  task automatic setLv(input int t, input int r, input logic e, input logic o);
    @(posedge clock);
    load <= 1'b1;
    loadTx <= LW'(t);
    loadRx <= LW'(r);
    @(posedge clock);
    load <= 1'b0;
    // error and timeout move with the level so no stale mix is seen
    rxFifoError <= e;
    rxTimeoutIrq <= o;
    @(posedge clock);
    @(negedge clock);
  endtask : setLv

  task automatic waitClk(input logic v, input int lim);
    int n;
    n = 0;
    while (clkEn !== v && n < lim)
    begin
      @(negedge clock);
      n++;
    end
    chk(clkEn, v);
    if (n >= lim)
      test_done();
  endtask : waitClk

  initial
  begin
    repeat (100000) @(posedge clock);
    numErrors++;
    test_done();
  end

  initial
  begin
    logic [31:0] q;
    logic [7:0] v;
    logic [1:0] req;
    logic e, o, s;
    int t, r, n;
    void'($urandom(28918));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk({txReqN, rxReqN, txPin, baudTick16}, 4'b0110);
    for (int i = 0; i < 7; i++)
    begin
      rd(ofs[i], q);
      chk(q, (i == 2) ? {24'h0, RST_LINE_CONTROL} : 32'h0);
    end
    for (int i = 0; i < 7; i++)
    begin
      v = 8'($urandom);
      wr(ofs[i], v);
      bus(1'b1, ofs[i], ~v, 4'h0, q);
      rd(ofs[i], q);
      chk(q, {24'h0, v});
      if (i == 2)
        chk(lineControl, v);
      wr(ofs[i], 8'h00);
    end
    rd(5'h03, q);
    chk(q, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      wr(OFS_IRQ_ENABLE, 8'(i));
      v = 8'($urandom);
      e = 1'($urandom);
      lineStatus <= v;
      irqPending <= e;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk(irqOut, (i != 0) && e);
      rd(OFS_STATUS, q);
      chk({q[14], q[7:0]}, {i != 0, v});
    end
    for (int i = 0; i < 24; i++)
    begin
      wr(OFS_FIFO_CONTROL, md[i % 3]);
      t = (i < 6) ? i % 2 : $urandom_range(DEPTH);
      r = (i < 6) ? i / 3 : $urandom_range(DEPTH);
      setLv(t, r, 1'b0, 1'b0);
      chk({txReqN, rxReqN}, {t != 0, r == 0});
    end
    wr(OFS_FIFO_CONTROL, 8'h09);
    req = 2'b11;
    for (int i = 0; i < 40; i++)
    begin
      t = (i < 7) ? tt[i] : $urandom_range(DEPTH);
      r = (i < 7) ? rr[i] : $urandom_range(DEPTH);
      e = (i < 7) ? ee[i] : ($urandom_range(7) == 0);
      o = (i < 7) ? oo[i] : ($urandom_range(3) == 0);
      req = blockReq(req, t, r, e, o);
      setLv(t, r, e, o);
      chk({txReqN, rxReqN}, req);
    end
    setLv(0, 0, 1'b0, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      wr(OFS_MODEM_CONTROL, {bp[i], 7'h00});
      wr(OFS_DIV_LOW, bd[i][7:0]);
      wr(OFS_DIV_HIGH, bd[i][15:8]);
      repeat (30) @(posedge clock);
      n = 0;
      repeat (bw[i])
      begin
        @(negedge clock);
        n += baudTick16;
      end
      chk(n, tickExp(int'(bd[i]), bp[i], bw[i]));
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(OFS_LINE_CONTROL, (b == 1) ? 8'h40 : 8'h00);
      s = 1'b1;
      for (int k = 0; k < 20; k++)
      begin
        @(posedge clock);
        txSerial <= 1'($urandom);
        @(negedge clock);
        if (k > 0)
          chk(txPin, (b == 1) ? 1'b0 : s);
        s = txSerial;
      end
    end
    // divisor is set up while sleep is still disabled
    wr(OFS_MODEM_CONTROL, 8'h00);
    wr(OFS_DIV_LOW, 8'h01);
    wr(OFS_DIV_HIGH, 8'h00);
    wr(OFS_FIFO_CONTROL, 8'h00);
    wr(OFS_LINE_CONTROL, 8'h00);
    wr(OFS_ENH_FEATURE, 8'h10);
    wr(OFS_IRQ_ENABLE, 8'h10);
    setLv(0, 1, 1'b0, 1'b0);
    rxPin <= 1'b0;
    repeat (20) @(posedge clock);
    rxPin <= 1'b1;
    repeat (480) @(posedge clock);
    rd(OFS_STATUS, q);
    chk(q[15:13], 3'b000);
    repeat (120) @(posedge clock);
    rd(OFS_STATUS, q);
    chk(q[15:13], 3'b001);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      otherIrq <= (k == 0);
      shiftEmpty <= (k == 0);
      setLv(0, 0, 1'b0, 1'b0);
      chk(clkEn, 1'b1);
    end
    @(posedge clock);
    shiftEmpty <= 1'b1;
    setLv(0, 0, 1'b0, 1'b0);
    waitClk(1'b0, 10);
    n = 0;
    repeat (20)
    begin
      @(negedge clock);
      n += baudTick16;
    end
    chk(n, 0);
    @(posedge clock);
    modemPins <= 4'h5;
    waitClk(1'b1, 8);
    waitClk(1'b0, 40);
    @(posedge clock);
    rxPin <= 1'b0;
    waitClk(1'b1, 8);
    @(posedge clock);
    rxPin <= 1'b1;
    wr(OFS_LINE_CONTROL, 8'h03);
    repeat (600) @(negedge clock);
    chk(clkEn, 1'b1);
    waitClk(1'b0, 200);
    @(posedge clock);
    service <= 1'b1;
    waitClk(1'b1, 8);
    @(posedge clock);
    service <= 1'b0;
    setLv(0, 0, 1'b0, 1'b0);
    wr(OFS_ENH_FEATURE, 8'h00);
    repeat (700) @(posedge clock);
    @(negedge clock);
    chk(clkEn, 1'b1);
    test_done();
  end
endmodule : uds_ctrl_tb
`default_nettype wire
